/* File: bench/dofs_act.sv */
`timescale 1ns/1ns
`default_nettype none
module dofs_act (
  // Clock
  input wire logic i_mclk,
  // Levels from the block
  input wire logic i_out_one,
  input wire logic i_out_two,
  input wire logic i_relay_closed,
  // Coil states
  output logic [2:0] o_energised
);
  // Coils pull in one clock late, like a slow relay; never earlier
  always_ff @(posedge i_mclk) begin
    o_energised <= {i_relay_closed, i_out_one, i_out_two};
  end
endmodule
`default_nettype wire

/* File: bench/dofs_top_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module dofs_top_chk #(
  parameter PLS_W = 8
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst,
  // Bus
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  input wire [31:0] o_hrdata,
  input wire o_hreadyout,
  // Levels
  input wire [1:0] i_fb_level,
  input wire i_fault,
  input wire i_drive_enabled,
  input wire o_output_one,
  input wire o_output_two,
  input wire o_relay_closed
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire tk = i_hsel & i_htrans[1] & i_hready;
  reg wp, rp, z1, z2;
  reg [2:0] wa;
  reg [1:0] ctl, usr, up;
  ////////////////////////////////////////////////////////////////////////
  // Shadow of the settings, so outputs can be judged from the ports alone
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      {wp, rp, wa, ctl, usr, up} <= 11'h000;
      {z1, z2} <= 2'h3;
    end else begin
      wp <= tk & i_hwrite;
      rp <= (tk & !i_hwrite) | (rp & !o_hreadyout);
      wa <= i_haddr[4:2];
      if (up != 2'h2) up <= up + 2'h1;
      if (wp & wa == 3'h0) ctl <= i_hwdata[1:0];
      if (wp & wa == 3'h2) usr <= i_hwdata[1:0];
      if (wp & wa == 3'h3 & i_hwdata < 32'h16) z1 <= i_hwdata == 32'h0;
      if (wp & wa == 3'h5 & i_hwdata < 32'h16) z2 <= i_hwdata == 32'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_rtake; tk && !i_hwrite; endsequence
  sequence s_rwait; !o_hreadyout ##1 o_hreadyout; endsequence
  sequence s_lvl; s_rtake ##0 i_haddr[4:2] == 3'h1; endsequence
  property p_rd_wait; s_rtake |=> s_rwait; endproperty
  property p_hold; !(rp & !o_hreadyout) |=> $stable(o_hrdata); endproperty
  property p_src_fb;
    up == 2'h2 && $past(ctl[0]) |-> {o_output_two, o_output_one} == $past(i_fb_level);
  endproperty
  property p_relay0;
    up == 2'h2 && !$past(ctl[1]) |-> o_relay_closed == !$past(i_fault);
  endproperty
  property p_relay1;
    up == 2'h2 && $past(ctl[1]) |-> o_relay_closed == $past(i_drive_enabled);
  endproperty
  property p_lvl;
    s_lvl |-> ##2 o_hrdata ==
      {29'h0, $past(o_relay_closed), $past(o_output_one), $past(o_output_two)};
  endproperty
  property p_user1;
    up == 2'h2 && !$past(ctl[0]) && $past(z1) |-> o_output_one == $past(usr[0]);
  endproperty
  property p_user2;
    up == 2'h2 && !$past(ctl[0]) && $past(z2) |-> o_output_two == $past(usr[1]);
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");
  a_hold: assert property (p_hold)
    else $error("read data moved");
  a_src_fb: assert property (p_src_fb)
    else $error("fieldbus level not followed");
  a_relay0: assert property (p_relay0)
    else $error("relay not following fault");
  a_relay1: assert property (p_relay1)
    else $error("relay not following enable");
  a_lvl: assert property (p_lvl)
    else $error("level word differs from outputs");
  a_user1: assert property (p_user1)
    else $error("output one not at user level");
  a_user2: assert property (p_user2)
    else $error("output two not at user level");
endmodule
bind dofs_top dofs_top_chk #(.PLS_W(PLS_W)) u_chk (.i_mclk, .i_rst, .i_hsel, .i_haddr,
  .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .i_fb_level,
  .i_fault, .i_drive_enabled, .o_output_one, .o_output_two, .o_relay_closed);
`default_nettype wire

/* File: bench/test_dofs_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dofs_map.vh"
module test_dofs_top;
  logic i_mclk = 1'h0, i_rst = 1'h1, i_hsel = 1'h0, i_hwrite = 1'h0, rdp = 1'h0;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, pos = 32'h0, vel = 32'h0;
  logic [1:0] i_htrans = 2'h0, fb = 2'h0, usr;
  logic [13:0] cnd = 14'h0;
  logic [7:0] pls = 8'h0;
  logic [4:0] c;
  logic [31:0] q[$];
  wire logic [31:0] o_hrdata;
  wire logic o_hreadyout, o1, o2, rly, hresp;
  wire logic [2:0] act;
  int seed = 8, bad_count = 0, checks_done = 0;
  int m[22] = '{0, 0, 1, 2, 3, 0, 0, 4, 5, 0, 6, 7, 0, 0, 8, 0, 9, 10, 0, 11, 12, 13};
  dofs_top dut (.i_mclk, .i_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata,
    .i_hsize(3'h2), .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp(hresp),
    .i_fb_level(fb), .i_mains_ready(cnd[0]), .i_sw_limit(cnd[1]), .i_move_done(cnd[2]),
    .i_in_pos(cnd[3]), .i_warning(cnd[4]), .i_drive_enabled(cnd[5]), .i_brake(cnd[6]),
    .i_fault(cnd[7]), .i_homed(cnd[8]), .i_pls_bits(pls), .i_cmd_buf_active(cnd[9]),
    .i_mt_in_pos(cnd[10]), .i_enc_index(cnd[11]), .i_ctrl_stop(cnd[12]),
    .i_fault_pwr(cnd[13]), .i_position(pos), .i_velocity(vel), .i_pos_min(32'hFFFFFF9C),
    .i_pos_max(32'h64), .i_vel_max(32'h1F4), .o_output_one(o1), .o_output_two(o2),
    .o_relay_closed(rly));
  dofs_act u_act (.i_mclk, .i_out_one(o1), .i_out_two(o2), .i_relay_closed(rly),
    .o_energised(act));
  initial begin
    forever #50 i_mclk = ~i_mclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t: read %h, expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task rdy;
    for (int k = 0; k < 20; k++) begin
      @(posedge i_mclk);
      if (o_hreadyout === 1'h1) return;
    end
    bad_count++;
    finish_test;
  endtask
  // For a read, d is the expected word, noted for the monitor
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    i_hsel <= 1'h1;
    i_htrans <= 2'h2;
    i_hwrite <= w;
    i_haddr <= {27'h0, a};
    rdy;
    i_htrans <= 2'h0;
    i_hsel <= 1'h0;
    i_hwdata <= w ? d : 32'h0;
    if (!w) q.push_back(d);
    rdy;
  endtask
  function logic fx(input logic [4:0] k);
    case (k)
      5'h00: fx = usr[0];
      5'h05: fx = $signed(pos) > 0;
      5'h06: fx = $signed(pos) < 0;
      5'h0C: fx = vel != 32'h0;
      5'h0F: fx = |pls;
      5'h09, 5'h0D, 5'h12: fx = 1'h0;
      default: fx = cnd[m[k]];
    endcase
  endfunction
  function logic [31:0] lv(input logic [4:0] k, input logic p);
    lv = {29'h0, p ? cnd[5] : !cnd[7], fx(k), usr[1]};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  always @(posedge i_mclk) begin
    if (rdp && o_hreadyout === 1'h1) check(o_hrdata, q.pop_front());
    if (rdp && o_hreadyout === 1'h1) check({31'h0, hresp}, 32'h0);
    rdp <= (i_hsel & i_htrans[1] & o_hreadyout & !i_hwrite) | (rdp & !o_hreadyout);
  end
  initial begin
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'h0;
    @(posedge i_mclk);
    bus(0, `DOFS_OFS_CTRL, 32'h0);
    bus(0, `DOFS_OFS_CODE1, 32'h0);
    bus(0, `DOFS_OFS_THR1, 32'h0);
    bus(0, 5'h1C, 32'h0);
    usr = 2'($random(seed));
    bus(1, `DOFS_OFS_USER, {30'h0, usr});
    // Every code, each with fresh drive conditions
    for (c = 5'h00; c != 5'h16; c++) begin
      cnd <= 14'($random(seed));
      pos <= $random(seed);
      vel <= $random(seed);
      pls <= 8'($random(seed) & 3);
      bus(1, `DOFS_OFS_CODE1, {27'h0, c});
      bus(0, `DOFS_OFS_LEVEL, lv(c, 1'h0));
    end
    bus(1, `DOFS_OFS_CODE1, 32'h5);
    bus(1, `DOFS_OFS_THR1, 32'h32);
    bus(1, `DOFS_OFS_CODE1, 32'h5);
    bus(1, `DOFS_OFS_THR1, 32'hC8);
    bus(0, `DOFS_OFS_THR1, 32'h32);
    bus(1, `DOFS_OFS_CODE1, 32'hC);
    bus(0, `DOFS_OFS_THR1, 32'h0);
    bus(1, `DOFS_OFS_THR1, 32'h1F5);
    bus(0, `DOFS_OFS_THR1, 32'h0);
    bus(1, `DOFS_OFS_THR1, 32'h1F4);
    bus(0, `DOFS_OFS_THR1, 32'h1F4);
    bus(1, `DOFS_OFS_CODE1, 32'h16);
    bus(1, `DOFS_OFS_CODE1, 32'h20);
    bus(0, `DOFS_OFS_CODE1, 32'hC);
    bus(1, `DOFS_OFS_CODE1, 32'h0);
    bus(1, `DOFS_OFS_THR1, 32'h1);
    bus(0, `DOFS_OFS_THR1, 32'h0);
    // Output two through its own code and threshold registers
    bus(1, `DOFS_OFS_CODE2, 32'hB);
    bus(1, `DOFS_OFS_THR2, 32'h1);
    bus(0, `DOFS_OFS_THR2, 32'h0);
    bus(0, `DOFS_OFS_LEVEL, {29'h0, !cnd[7], usr[0], cnd[7]});
    bus(0, `DOFS_OFS_CODE2, 32'hB);
    bus(1, `DOFS_OFS_CODE2, 32'h0);
    bus(1, `DOFS_OFS_CTRL, 32'h2);
    repeat (3) begin
      cnd <= 14'($random(seed));
      @(posedge i_mclk);
      bus(0, `DOFS_OFS_LEVEL, lv(5'h00, 1'h1));
    end
    bus(1, `DOFS_OFS_CTRL, 32'h3);
    fb <= 2'($random(seed));
    @(posedge i_mclk);
    bus(0, `DOFS_OFS_LEVEL, {29'h0, cnd[5], fb[0], fb[1]});
    bus(0, `DOFS_OFS_CTRL, 32'h3);
    // Coils have long settled on the steady levels by now
    check({29'h0, act}, {29'h0, cnd[5], fb[0], fb[1]});
    finish_test;
  end
endmodule
`default_nettype wire

/* File: rtl/dofs_map.vh */
`ifndef DOFS_MAP_VH
`define DOFS_MAP_VH

// Register byte offsets
`define DOFS_OFS_CTRL 5'h00
`define DOFS_OFS_LEVEL 5'h04
`define DOFS_OFS_USER 5'h08
`define DOFS_OFS_CODE1 5'h0C
`define DOFS_OFS_THR1 5'h10
`define DOFS_OFS_CODE2 5'h14
`define DOFS_OFS_THR2 5'h18

// Field positions
`define DOFS_CTRL_SRC 0
`define DOFS_CTRL_RELAY 1
`define DOFS_LEVEL_OUT2 0
`define DOFS_LEVEL_OUT1 1
`define DOFS_LEVEL_RELAY 2

// Reset values
`define DOFS_RST_SRC 1'h0
`define DOFS_RST_RELAY 1'h0
`define DOFS_RST_CODE 5'h00
`define DOFS_RST_THR 32'h00000000
`define DOFS_RST_USER 1'h0

// Function codes
`define DOFS_FC_USER 5'h00
`define DOFS_FC_MAINS 5'h01
`define DOFS_FC_SWLIM 5'h02
`define DOFS_FC_MOVEDONE 5'h03
`define DOFS_FC_INPOS 5'h04
`define DOFS_FC_POS_GT 5'h05
`define DOFS_FC_POS_LT 5'h06
`define DOFS_FC_WARN 5'h07
`define DOFS_FC_ENABLED 5'h08
`define DOFS_FC_BRAKE 5'h0A
`define DOFS_FC_FAULT 5'h0B
`define DOFS_FC_VEL_GT 5'h0C
`define DOFS_FC_VEL_LT 5'h0D
`define DOFS_FC_HOMED 5'h0E
`define DOFS_FC_PLS_OR 5'h0F
`define DOFS_FC_CMDBUF 5'h10
`define DOFS_FC_MT_INPOS 5'h11
`define DOFS_FC_INDEX 5'h13
`define DOFS_FC_CSTOP 5'h14
`define DOFS_FC_FAULT_PWR 5'h15
`define DOFS_FC_MAX 5'h15

`endif

/* File: rtl/dofs_sel.v */
`timescale 1ns/1ns
`default_nettype none
`include "dofs_map.vh"

module dofs_sel #(
  parameter PLS_W = 8
) (
  // Selection
  input wire [4:0] i_code,
  input wire [31:0] i_thr,
  // Drive conditions
  input wire i_mains_ready,
  input wire i_sw_limit,
  input wire i_move_done,
  input wire i_in_pos,
  input wire i_warning,
  input wire i_drive_enabled,
  input wire i_brake,
  input wire i_fault,
  input wire i_homed,
  input wire [PLS_W-1:0] i_pls_bits,
  input wire i_cmd_buf_active,
  input wire i_mt_in_pos,
  input wire i_enc_index,
  input wire i_ctrl_stop,
  input wire i_fault_pwr,
  input wire [31:0] i_position,
  input wire [31:0] i_velocity,
  // Result
  output reg o_cond
);

  reg [31:0] abs_vel;

  always @* begin
    abs_vel = i_velocity[31] ? (32'h00000000 - i_velocity) : i_velocity;
    case (i_code)
      `DOFS_FC_MAINS: o_cond = i_mains_ready;
      `DOFS_FC_SWLIM: o_cond = i_sw_limit;
      `DOFS_FC_MOVEDONE: o_cond = i_move_done;
      `DOFS_FC_INPOS: o_cond = i_in_pos;
      `DOFS_FC_POS_GT: o_cond = $signed(i_position) > $signed(i_thr);
      `DOFS_FC_POS_LT: o_cond = $signed(i_position) < $signed(i_thr);
      `DOFS_FC_WARN: o_cond = i_warning;
      `DOFS_FC_ENABLED: o_cond = i_drive_enabled;
      `DOFS_FC_BRAKE: o_cond = i_brake;
      `DOFS_FC_FAULT: o_cond = i_fault;
      `DOFS_FC_VEL_GT: o_cond = abs_vel > i_thr;
      `DOFS_FC_VEL_LT: o_cond = abs_vel < i_thr;
      `DOFS_FC_HOMED: o_cond = i_homed;
      `DOFS_FC_PLS_OR: o_cond = |i_pls_bits;
      `DOFS_FC_CMDBUF: o_cond = i_cmd_buf_active;
      `DOFS_FC_MT_INPOS: o_cond = i_mt_in_pos;
      `DOFS_FC_INDEX: o_cond = i_enc_index;
      `DOFS_FC_CSTOP: o_cond = i_ctrl_stop;
      `DOFS_FC_FAULT_PWR: o_cond = i_fault_pwr;
      // Reserved codes 9 and 18 hold the output inactive
      default: o_cond = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

/* File: rtl/dofs_top.v */
`timescale 1ns/1ns
`default_nettype none
`include "dofs_map.vh"

// Summary of operation
// - Output control comes from firmware when the source select is 0 and from the fieldbus when 1, resetting to 0.
// - With relay policy 0 the fault relay opens while the fault input is active (not on a power-stage fault) and closes when it is clear, policy resetting to 0.
// - With relay policy 1 the fault relay opens while the drive is disabled and closes while it is enabled.
// - The read-only level word shows output one in its left bit and output two in its right bit.
// - Each function code resets to 0 (user level) and only codes 0 to 21 are accepted.
// - Codes 1 to 8 select mains ready, software limit, move complete, in position, position above, position below, warning and enabled.
// - Code 9 is reserved and codes 10 to 14 select brake, fault, speed above, speed below and homing complete.
// - Codes 15 to 21 select limit-switch OR, command buffer, motion task in position, index pulse (19), controlled stop and power-stage fault (21).
// - Thresholds reset to 0 and codes without a listed range accept only the value 0.
// - Codes 4, 5 and 6 accept thresholds between the position minimum and maximum.
// - Codes 12 and 13 accept thresholds from zero up to the velocity maximum.
// - Writing a different function code clears that output's threshold to zero.
// - In user code with source select 0, each output follows its user level bit, 0 inactive and 1 active.
module dofs_top #(
  parameter PLS_W = 8
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst,
  // AHB-Lite slave
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg [31:0] o_hrdata,
  output reg o_hreadyout,
  output reg o_hresp,
  // Fieldbus output levels
  input wire [1:0] i_fb_level,
  // Drive conditions
  input wire i_mains_ready,
  input wire i_sw_limit,
  input wire i_move_done,
  input wire i_in_pos,
  input wire i_warning,
  input wire i_drive_enabled,
  input wire i_brake,
  input wire i_fault,
  input wire i_homed,
  input wire [PLS_W-1:0] i_pls_bits,
  input wire i_cmd_buf_active,
  input wire i_mt_in_pos,
  input wire i_enc_index,
  input wire i_ctrl_stop,
  input wire i_fault_pwr,
  input wire [31:0] i_position,
  input wire [31:0] i_velocity,
  // Range limits in user units
  input wire [31:0] i_pos_min,
  input wire [31:0] i_pos_max,
  input wire [31:0] i_vel_max,
  // Outputs
  output reg o_output_one,
  output reg o_output_two,
  output reg o_relay_closed
);

  ////////////////////////////////////////////////////////////////////////////////
  // Storage

  reg output_source_select;
  reg fault_relay_policy;
  reg [1:0] user_output_level;
  reg [4:0] output_function_code [0:1];
  reg [31:0] output_threshold_value [0:1];

  reg wr_pend;
  reg rd_pend;
  reg [4:0] ph_addr;

  wire [1:0] cond;
  wire [1:0] level_pair;
  integer k;

  assign level_pair = {o_output_one, o_output_two};

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Output index of a per-output register, 2'h2 when the offset is not one
  function [1:0] chan_of;
    input [4:0] addr;
    input is_thr;
    begin
      if (addr == (is_thr ? `DOFS_OFS_THR1 : `DOFS_OFS_CODE1)) begin
        chan_of = 2'h0;
      end else if (addr == (is_thr ? `DOFS_OFS_THR2 : `DOFS_OFS_CODE2)) begin
        chan_of = 2'h1;
      end else begin
        chan_of = 2'h2;
      end
    end
  endfunction

  // Legal threshold for a given function code
  function thr_ok;
    input [4:0] code;
    input [31:0] val;
    input [31:0] pmin;
    input [31:0] pmax;
    input [31:0] vmax;
    begin
      case (code)
        `DOFS_FC_INPOS, `DOFS_FC_POS_GT, `DOFS_FC_POS_LT: begin
          thr_ok = ($signed(val) >= $signed(pmin)) && ($signed(val) <= $signed(pmax));
        end
        `DOFS_FC_VEL_GT, `DOFS_FC_VEL_LT: begin
          thr_ok = !val[31] && ($signed(val) <= $signed(vmax));
        end
        default: begin
          thr_ok = (val == 32'h00000000);
        end
      endcase
    end
  endfunction

  function [31:0] read_word;
    input [4:0] addr;
    input [1:0] ch_code;
    input [1:0] ch_thr;
    begin
      read_word = 32'h00000000;
      if (addr == `DOFS_OFS_CTRL) begin
        read_word[`DOFS_CTRL_SRC] = output_source_select;
        read_word[`DOFS_CTRL_RELAY] = fault_relay_policy;
      end else if (addr == `DOFS_OFS_LEVEL) begin
        read_word[`DOFS_LEVEL_OUT1:`DOFS_LEVEL_OUT2] = level_pair;
        read_word[`DOFS_LEVEL_RELAY] = o_relay_closed;
      end else if (addr == `DOFS_OFS_USER) begin
        read_word[1:0] = user_output_level;
      end else if (ch_code != 2'h2) begin
        read_word[4:0] = output_function_code[ch_code[0]];
      end else if (ch_thr != 2'h2) begin
        read_word = output_threshold_value[ch_thr[0]];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave

  wire addr_take;
  wire [1:0] wr_code_ch;
  wire [1:0] wr_thr_ch;
  wire [4:0] wr_code_val;

  // Unmapped offsets read as zero and drop writes; every response is OKAY
  assign addr_take = i_hsel && i_htrans[1] && i_hready;
  assign wr_code_ch = chan_of(ph_addr, 1'b0);
  assign wr_thr_ch = chan_of(ph_addr, 1'b1);
  assign wr_code_val = i_hwdata[4:0];

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ph_addr <= 5'h00;
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      if (rd_pend) begin
        // One wait state so a read sees any write that finished just before it
        o_hrdata <= read_word(ph_addr, chan_of(ph_addr, 1'b0), chan_of(ph_addr, 1'b1));
        o_hreadyout <= 1'b1;
        rd_pend <= 1'b0;
        wr_pend <= 1'b0;
      end else if (addr_take) begin
        ph_addr <= {i_haddr[4:2], 2'b00};
        wr_pend <= i_hwrite;
        rd_pend <= !i_hwrite;
        o_hreadyout <= i_hwrite;
      end else begin
        wr_pend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      output_source_select <= `DOFS_RST_SRC;
      fault_relay_policy <= `DOFS_RST_RELAY;
      user_output_level <= {2{`DOFS_RST_USER}};
      for (k = 0; k < 2; k = k + 1) begin
        output_function_code[k] <= `DOFS_RST_CODE;
        output_threshold_value[k] <= `DOFS_RST_THR;
      end
    end else if (wr_pend) begin
      if (ph_addr == `DOFS_OFS_CTRL) begin
        output_source_select <= i_hwdata[`DOFS_CTRL_SRC];
        fault_relay_policy <= i_hwdata[`DOFS_CTRL_RELAY];
      end
      if (ph_addr == `DOFS_OFS_USER) begin
        user_output_level <= i_hwdata[1:0];
      end
      // Codes above the top one, or with upper bits set, are refused
      if (wr_code_ch != 2'h2 && i_hwdata[31:5] == 27'h0000000 &&
          wr_code_val <= `DOFS_FC_MAX) begin
        output_function_code[wr_code_ch[0]] <= wr_code_val;
        if (wr_code_val != output_function_code[wr_code_ch[0]]) begin
          output_threshold_value[wr_code_ch[0]] <= 32'h00000000;
        end
      end
      // A threshold outside the current code's range leaves the old value
      if (wr_thr_ch != 2'h2 &&
          thr_ok(output_function_code[wr_thr_ch[0]], i_hwdata, i_pos_min, i_pos_max,
                 i_vel_max)) begin
        output_threshold_value[wr_thr_ch[0]] <= i_hwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Condition selection

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sel
      dofs_sel #(
        .PLS_W(PLS_W)
      ) u_sel (
        .i_code(output_function_code[g]),
        .i_thr(output_threshold_value[g]),
        .i_mains_ready(i_mains_ready),
        .i_sw_limit(i_sw_limit),
        .i_move_done(i_move_done),
        .i_in_pos(i_in_pos),
        .i_warning(i_warning),
        .i_drive_enabled(i_drive_enabled),
        .i_brake(i_brake),
        .i_fault(i_fault),
        .i_homed(i_homed),
        .i_pls_bits(i_pls_bits),
        .i_cmd_buf_active(i_cmd_buf_active),
        .i_mt_in_pos(i_mt_in_pos),
        .i_enc_index(i_enc_index),
        .i_ctrl_stop(i_ctrl_stop),
        .i_fault_pwr(i_fault_pwr),
        .i_position(i_position),
        .i_velocity(i_velocity),
        .o_cond(cond[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Output drivers

  reg [1:0] next_level;
  integer m;

  always @* begin
    next_level = 2'b00;
    for (m = 0; m < 2; m = m + 1) begin
      if (output_source_select) begin
        next_level[m] = i_fb_level[m];
      end else if (output_function_code[m] == `DOFS_FC_USER) begin
        next_level[m] = user_output_level[m];
      end else begin
        next_level[m] = cond[m];
      end
    end
  end

  // Registered every cycle; the level word reads these same flops
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_output_one <= 1'b0;
      o_output_two <= 1'b0;
      o_relay_closed <= 1'b0;
    end else begin
      o_output_one <= next_level[0];
      o_output_two <= next_level[1];
      if (fault_relay_policy) begin
        o_relay_closed <= i_drive_enabled;
      end else begin
        o_relay_closed <= !i_fault;
      end
    end
  end

endmodule
`default_nettype wire
